// file: app_defines.svh
// Constants for the assisted parallel port
`ifndef APP_DEFINES_SVH
`define APP_DEFINES_SVH
`define APP_ADDR_W 4
`define APP_OFF_DATA0 4'h0
`define APP_OFF_DATA1 4'h1
`define APP_OFF_DATA2 4'h2
`define APP_OFF_CFG 4'h3
`define APP_OFF_IRQ_STAT 4'h4
`define APP_OFF_IRQ_EN 4'h5
`define APP_OFF_IRQ_CLR 4'h6
`define APP_OFF_ENABLE 4'h7
`define APP_CFG_WIDTH_LO 0
`define APP_CFG_WIDTH_HI 1
`define APP_CFG_ORDY 2
`define APP_CFG_IROOM 3
`define APP_CFG_ORDY_POL 4
`define APP_CFG_IROOM_POL 5
`define APP_IRQ_READ_DONE 0
`define APP_IRQ_WRITE_DONE 1
`define APP_IRQ_W 2
`define APP_ENABLE_BIT 0
`define APP_WIDTH_8 2'h0
`define APP_WIDTH_16 2'h1
`define APP_WIDTH_24 2'h2
`define APP_CFG_RESET 8'h00
`define APP_BYTE_ZERO 8'h00
`endif

// file: app_pkg.sv
// Types shared by the assisted parallel port
`default_nettype none
package app_pkg;
	typedef logic [7:0] app_byte_t;
	typedef enum logic [1:0]
	{
		APP_IDLE = 2'b00,
		APP_READ = 2'b01,
		APP_WRITE = 2'b10
	} app_state_e;
endpackage
`default_nettype wire

// file: app_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module app_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
)(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic enable_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_nxt;

	always_comb
	begin
		meta_nxt = enable_in ? async_in : meta_r;
		sync_nxt = enable_in ? meta_r : sync_out;
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
		begin
			meta_r <= INIT;
			sync_out <= INIT;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_out <= sync_nxt;
		end
	end
endmodule
`default_nettype wire

// file: app_port.sv
// Assisted parallel port: pin handshake, data latches, registers
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "app_defines.svh"
// How it works
// - Transfer width 8, 16 or 24 bits from config bits 1:0.
// - Enabled port drives handshake pins push-pull; control pins pure inputs.
// - Pins: input-room, output-ready, strobe, read enable, select.
// - Port 0 data write sets output-ready until select and read enable go low.
// - Port 0 data read sets input-room until select and write strobe go low.
// - Config bit 4 sets output-ready polarity; flag is pin inverse.
// - Config bit 5 sets input-room polarity; flag is pin inverse.
// - Select and read enable low drive output latches onto data pins.
// - Read enable returning high raises the interrupt.
// - Select and strobe low capture data and drop input-room.
// - Write strobe returning high raises the interrupt.
// - Only port 0 accesses change the handshake flags.
module app_port
	import app_pkg::*;
#(
	parameter int DATA_BYTES = 3
)(
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic [`APP_ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic irq_out,
	input wire logic write_strobe_n_in,
	input wire logic read_enable_n_in,
	input wire logic select_n_in,
	input wire logic [8*DATA_BYTES-1:0] data_pin_in,
	output logic [8*DATA_BYTES-1:0] data_pin_out,
	output logic [DATA_BYTES-1:0] data_pin_oe_out,
	output logic input_room_pin_out,
	output logic output_ready_pin_out,
	output logic handshake_oe_out
);
	// Lane decode and register map serve exactly three bytes
	if (DATA_BYTES != 3)
	begin : bad_bytes
		$error("DATA_BYTES must be 3");
	end

	logic stb_s, oe_s, cs_s;
	logic [8*DATA_BYTES-1:0] din_s;
	app_sync2 #(.WIDTH(3), .INIT(3'h7)) u_ctl_sync (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.enable_in(clk_en_in),
		.async_in({write_strobe_n_in, read_enable_n_in, select_n_in}),
		.sync_out({stb_s, oe_s, cs_s})
	);
	app_sync2 #(.WIDTH(8*DATA_BYTES), .INIT('0)) u_data_sync (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.enable_in(clk_en_in),
		.async_in(data_pin_in),
		.sync_out(din_s)
	);

	app_byte_t out_lat_r [DATA_BYTES];
	app_byte_t out_lat_nxt [DATA_BYTES];
	app_byte_t in_lat_r [DATA_BYTES];
	app_byte_t in_lat_nxt [DATA_BYTES];
	logic [1:0] width_r, width_nxt;
	logic ordy_pol_r, ordy_pol_nxt;
	logic iroom_pol_r, iroom_pol_nxt;
	logic enable_r, enable_nxt;
	logic ordy_r, ordy_nxt;
	logic iroom_r, iroom_nxt;
	app_state_e state_r, state_nxt;
	logic [`APP_IRQ_W-1:0] stat_r, stat_nxt;
	logic [`APP_IRQ_W-1:0] irq_en_r, irq_en_nxt;
	logic [7:0] rdata_nxt;
	logic irq_nxt;
	logic [8*DATA_BYTES-1:0] dpin_nxt;
	logic [DATA_BYTES-1:0] doe_nxt;
	logic ipin_nxt, opin_nxt, hoe_nxt;
	logic read_act, write_act;
	logic [`APP_IRQ_W-1:0] ev;
	logic [DATA_BYTES-1:0] lane_on;
	logic [7:0] cfg_view;

	// Transaction decode; select gates both strobes
	assign read_act = enable_r && !cs_s && !oe_s;
	assign write_act = enable_r && !cs_s && !stb_s;

	always_comb
	begin
		// Lanes in use follow the chosen width
		unique case (width_r)
			`APP_WIDTH_8: lane_on = 3'b001;
			`APP_WIDTH_16: lane_on = 3'b011;
			default: lane_on = 3'b111;
		endcase
		// Flags read as the inverse of the pins
		cfg_view = `APP_BYTE_ZERO;
		cfg_view[`APP_CFG_WIDTH_HI:`APP_CFG_WIDTH_LO] = width_r;
		cfg_view[`APP_CFG_ORDY] = ordy_r ~^ ordy_pol_r;
		cfg_view[`APP_CFG_IROOM] = iroom_r ~^ iroom_pol_r;
		cfg_view[`APP_CFG_ORDY_POL] = ordy_pol_r;
		cfg_view[`APP_CFG_IROOM_POL] = iroom_pol_r;
	end

	always_comb
	begin
		state_nxt = state_r;
		ev = '0;
		unique case (state_r)
			APP_IDLE:
			begin
				if (read_act)
					state_nxt = APP_READ;
				else if (write_act)
					state_nxt = APP_WRITE;
			end
			APP_READ:
			begin
				if (!read_act)
				begin
					state_nxt = APP_IDLE;
					ev[`APP_IRQ_READ_DONE] = 1'b1;
				end
			end
			APP_WRITE:
			begin
				if (!write_act)
				begin
					state_nxt = APP_IDLE;
					ev[`APP_IRQ_WRITE_DONE] = 1'b1;
				end
			end
			default: state_nxt = APP_IDLE;
		endcase
	end

	always_comb
	begin
		out_lat_nxt = out_lat_r;
		in_lat_nxt = in_lat_r;
		width_nxt = width_r;
		ordy_pol_nxt = ordy_pol_r;
		iroom_pol_nxt = iroom_pol_r;
		enable_nxt = enable_r;
		ordy_nxt = ordy_r;
		iroom_nxt = iroom_r;
		irq_en_nxt = irq_en_r;
		rdata_nxt = `APP_BYTE_ZERO;
		// Capture while strobe active; latch then holds
		for (int i = 0; i < DATA_BYTES; i++)
			if (write_act && lane_on[i])
				in_lat_nxt[i] = din_s[8*i +: 8];
		if (write_act)
			iroom_nxt = 1'b0;
		if (read_act)
			ordy_nxt = 1'b0;
		if (wr_in)
		begin
			unique case (addr_in)
				`APP_OFF_DATA0:
				begin
					out_lat_nxt[0] = wdata_in;
					ordy_nxt = 1'b1;
				end
				`APP_OFF_DATA1: out_lat_nxt[1] = wdata_in;
				`APP_OFF_DATA2: out_lat_nxt[2] = wdata_in;
				`APP_OFF_CFG:
				begin
					width_nxt = wdata_in[`APP_CFG_WIDTH_HI:`APP_CFG_WIDTH_LO];
					ordy_pol_nxt = wdata_in[`APP_CFG_ORDY_POL];
					iroom_pol_nxt = wdata_in[`APP_CFG_IROOM_POL];
				end
				`APP_OFF_IRQ_EN: irq_en_nxt = wdata_in[`APP_IRQ_W-1:0];
				`APP_OFF_ENABLE: enable_nxt = wdata_in[`APP_ENABLE_BIT];
				default: ;
			endcase
		end
		if (rd_in)
		begin
			unique case (addr_in)
				`APP_OFF_DATA0:
				begin
					rdata_nxt = in_lat_r[0];
					// Room only after the read; a live strobe keeps it low
					if (!write_act)
						iroom_nxt = 1'b1;
				end
				`APP_OFF_DATA1: rdata_nxt = in_lat_r[1];
				`APP_OFF_DATA2: rdata_nxt = in_lat_r[2];
				`APP_OFF_CFG: rdata_nxt = cfg_view;
				`APP_OFF_IRQ_STAT: rdata_nxt[`APP_IRQ_W-1:0] = stat_r;
				`APP_OFF_IRQ_EN: rdata_nxt[`APP_IRQ_W-1:0] = irq_en_r;
				`APP_OFF_ENABLE: rdata_nxt[`APP_ENABLE_BIT] = enable_r;
				default: ;
			endcase
		end
		// Set beats clear in the same cycle
		stat_nxt = stat_r;
		if (wr_in && addr_in == `APP_OFF_IRQ_CLR)
			stat_nxt = stat_r & ~wdata_in[`APP_IRQ_W-1:0];
		stat_nxt = stat_nxt | ev;
		irq_nxt = |(stat_nxt & irq_en_nxt);
		// Pins: polarity bit set makes the pin active low
		opin_nxt = ordy_nxt ^ ordy_pol_nxt;
		ipin_nxt = iroom_nxt ^ iroom_pol_nxt;
		hoe_nxt = enable_nxt;
		for (int i = 0; i < DATA_BYTES; i++)
		begin
			dpin_nxt[8*i +: 8] = out_lat_nxt[i];
			doe_nxt[i] = read_act && lane_on[i];
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!reset_n_in)
		begin
			for (int i = 0; i < DATA_BYTES; i++)
			begin
				out_lat_r[i] <= `APP_BYTE_ZERO;
				in_lat_r[i] <= `APP_BYTE_ZERO;
			end
			width_r <= `APP_WIDTH_8;
			ordy_pol_r <= 1'b0;
			iroom_pol_r <= 1'b0;
			enable_r <= 1'b0;
			ordy_r <= 1'b0;
			iroom_r <= 1'b1;
			state_r <= APP_IDLE;
			stat_r <= '0;
			irq_en_r <= '0;
			rdata_out <= `APP_BYTE_ZERO;
			irq_out <= 1'b0;
			data_pin_out <= '0;
			data_pin_oe_out <= '0;
			output_ready_pin_out <= 1'b0;
			input_room_pin_out <= 1'b1;
			handshake_oe_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			out_lat_r <= out_lat_nxt;
			in_lat_r <= in_lat_nxt;
			width_r <= width_nxt;
			ordy_pol_r <= ordy_pol_nxt;
			iroom_pol_r <= iroom_pol_nxt;
			enable_r <= enable_nxt;
			ordy_r <= ordy_nxt;
			iroom_r <= iroom_nxt;
			state_r <= state_nxt;
			stat_r <= stat_nxt;
			irq_en_r <= irq_en_nxt;
			rdata_out <= rdata_nxt;
			irq_out <= irq_nxt;
			data_pin_out <= dpin_nxt;
			data_pin_oe_out <= doe_nxt;
			output_ready_pin_out <= opin_nxt;
			input_room_pin_out <= ipin_nxt;
			handshake_oe_out <= hoe_nxt;
		end
	end

	chk_ordy_on_write: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && wr_in && addr_in == `APP_OFF_DATA0 && !read_act
		|=> ordy_r) else $error("output-ready not set");
	chk_iroom_drop: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && write_act |=> !iroom_r)
		else $error("input-room not dropped");
	chk_iroom_on_read: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && rd_in && addr_in == `APP_OFF_DATA0 && !write_act
		|=> iroom_r) else $error("input-room not set");
	chk_ordy_pin_pol: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		output_ready_pin_out == (ordy_r ^ ordy_pol_r))
		else $error("output-ready pin polarity");
	chk_iroom_pin_pol: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		input_room_pin_out == (iroom_r ^ iroom_pol_r))
		else $error("input-room pin polarity");
	chk_read_drive: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && read_act |=> data_pin_oe_out[0])
		else $error("data not driven on read");
	chk_read_irq: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && state_r == APP_READ && !read_act
		|=> stat_r[`APP_IRQ_READ_DONE]) else $error("no read irq");
	chk_write_irq: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && state_r == APP_WRITE && !write_act
		|=> stat_r[`APP_IRQ_WRITE_DONE]) else $error("no write irq");
	chk_other_ports: assert property (@(posedge clock_in)
		disable iff (!reset_n_in)
		clk_en_in && wr_in && addr_in == `APP_OFF_DATA1 && !read_act
		|=> $stable(ordy_r)) else $error("port 1 moved handshake");
endmodule
`default_nettype wire

// file: app_ext_host.sv
// External parallel bus master model facing the port pins
`timescale 1ns/1ps
`default_nettype none
module app_ext_host (
	input wire logic clock_in,
	output logic select_n_out,
	output logic read_enable_n_out,
	output logic write_strobe_n_out,
	output logic [23:0] data_out
);
	initial
	begin
		select_n_out = 1'b1;
		read_enable_n_out = 1'b1;
		write_strobe_n_out = 1'b1;
		data_out = 24'h5a5a5a;
	end
	// Read enable falls as select takes sel_v; the two rise together
	task automatic ext_read(input int hold, input logic sel_v);
		@(posedge clock_in);
		select_n_out <= sel_v;
		read_enable_n_out <= 1'b0;
		repeat (hold) @(posedge clock_in);
		select_n_out <= 1'b1;
		read_enable_n_out <= 1'b1;
	endtask
	// Data stands with the strobe; three cycles after release the lines show the inverse
	task automatic ext_write(input logic [23:0] d, input int hold);
		@(posedge clock_in);
		data_out <= d;
		select_n_out <= 1'b0;
		write_strobe_n_out <= 1'b0;
		repeat (hold) @(posedge clock_in);
		select_n_out <= 1'b1;
		write_strobe_n_out <= 1'b1;
		repeat (3) @(posedge clock_in);
		data_out <= ~d;
	endtask
endmodule
`default_nettype wire

// file: app_port_bench.sv
// Self-checking bench for the assisted parallel port
`timescale 1ns/1ps
`default_nettype none
`include "app_defines.svh"
module app_port_bench;
	logic clk, rst_n, wr, rd, irq, stb_n, oe_n, sel_n, iroom, ordy, hs_oe;
	logic clk_en;
	logic [3:0] addr;
	logic [7:0] wdata, rdata;
	logic [23:0] host_d, pin_in, pin_out, lanes;
	logic [2:0] pin_oe;
	int bad_count = 0;
	int check_count = 0;
	int cyc = 0;
	// Device wins the lanes it enables, the host holds the rest
	assign lanes = {{8{pin_oe[2]}}, {8{pin_oe[1]}}, {8{pin_oe[0]}}};
	assign pin_in = (pin_out & lanes) | (host_d & ~lanes);
	app_port uut (.clock_in(clk), .reset_n_in(rst_n), .clk_en_in(clk_en),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .irq_out(irq), .write_strobe_n_in(stb_n),
		.read_enable_n_in(oe_n), .select_n_in(sel_n), .data_pin_in(pin_in),
		.data_pin_out(pin_out), .data_pin_oe_out(pin_oe),
		.input_room_pin_out(iroom), .output_ready_pin_out(ordy),
		.handshake_oe_out(hs_oe));
	app_ext_host host (.clock_in(clk), .select_n_out(sel_n),
		.read_enable_n_out(oe_n), .write_strobe_n_out(stb_n),
		.data_out(host_d));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			close_out();
		end
	end
	task automatic cmp(input string n, input logic [23:0] e,
		input logic [23:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp("rdata", 24'(e), 24'(rdata));
	endtask
	// Pins looked at mid-access, after the synchroniser delay
	task automatic chk_read(input logic sel_v, input logic [2:0] e_oe,
		input logic [23:0] e_d, input logic e_rdy);
		fork
			host.ext_read(10, sel_v);
			begin
				repeat (6) @(posedge clk);
				#1;
				cmp("lane_oe", 24'(e_oe), 24'(pin_oe));
				cmp("read_data", e_d, pin_out & lanes);
				cmp("ordy_pin", 24'(e_rdy), 24'(ordy));
			end
		join
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic chk_write(input logic [23:0] d);
		fork
			host.ext_write(d, 6);
			begin
				repeat (5) @(posedge clk);
				#1;
				cmp("iroom_pin", 24'h0, 24'(iroom));
			end
		join
		repeat (5) @(posedge clk);
		#1;
	endtask
	initial
	begin
		rst_n = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		clk_en = 1'b1;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(`APP_OFF_CFG, 8'h04);
		cmp("hs_oe", 24'h0, 24'(hs_oe));
		reg_rd(4'h9, 8'h00);
		reg_wr(4'h9, 8'hff);
		reg_wr(`APP_OFF_ENABLE, 8'h01);
		reg_wr(`APP_OFF_CFG, 8'h02);
		reg_wr(`APP_OFF_IRQ_EN, 8'h03);
		reg_rd(`APP_OFF_IRQ_EN, 8'h03);
		cmp("hs_oe", 24'h1, 24'(hs_oe));
		reg_wr(`APP_OFF_DATA2, 8'ha5);
		reg_wr(`APP_OFF_DATA1, 8'h3c);
		reg_rd(`APP_OFF_CFG, 8'h06);
		cmp("ordy_pin", 24'h0, 24'(ordy));
		reg_wr(`APP_OFF_DATA0, 8'h96);
		reg_rd(`APP_OFF_CFG, 8'h02);
		cmp("ordy_pin", 24'h1, 24'(ordy));
		chk_read(1'b1, 3'b000, 24'h0, 1'b1);
		reg_rd(`APP_OFF_IRQ_STAT, 8'h00);
		chk_read(1'b0, 3'b111, 24'ha53c96, 1'b0);
		cmp("irq", 24'h1, 24'(irq));
		reg_rd(`APP_OFF_IRQ_STAT, 8'h01);
		reg_wr(`APP_OFF_IRQ_CLR, 8'h01);
		reg_rd(`APP_OFF_IRQ_STAT, 8'h00);
		cmp("irq", 24'h0, 24'(irq));
		chk_write(24'h123456);
		cmp("irq", 24'h1, 24'(irq));
		reg_rd(`APP_OFF_IRQ_STAT, 8'h02);
		reg_rd(`APP_OFF_DATA2, 8'h12);
		reg_rd(`APP_OFF_DATA1, 8'h34);
		cmp("iroom_pin", 24'h0, 24'(iroom));
		reg_rd(`APP_OFF_DATA0, 8'h56);
		reg_rd(`APP_OFF_CFG, 8'h06);
		cmp("iroom_pin", 24'h1, 24'(iroom));
		reg_wr(`APP_OFF_IRQ_CLR, 8'h02);
		reg_wr(`APP_OFF_CFG, 8'h32);
		reg_rd(`APP_OFF_CFG, 8'h3a);
		cmp("ordy_pin", 24'h1, 24'(ordy));
		cmp("iroom_pin", 24'h0, 24'(iroom));
		reg_wr(`APP_OFF_CFG, 8'h00);
		reg_wr(`APP_OFF_IRQ_EN, 8'h02);
		reg_wr(`APP_OFF_DATA0, 8'h77);
		reg_rd(`APP_OFF_CFG, 8'h00);
		chk_read(1'b0, 3'b001, 24'h000077, 1'b0);
		cmp("irq", 24'h0, 24'(irq));
		reg_wr(`APP_OFF_IRQ_EN, 8'h03);
		reg_rd(`APP_OFF_IRQ_STAT, 8'h01);
		cmp("irq", 24'h1, 24'(irq));
		// Held clock enable must swallow a register write
		@(posedge clk);
		clk_en <= 1'b0;
		reg_wr(`APP_OFF_IRQ_EN, 8'h00);
		clk_en <= 1'b1;
		reg_rd(`APP_OFF_IRQ_EN, 8'h03);
		cmp("irq", 24'h1, 24'(irq));
		reg_wr(`APP_OFF_IRQ_CLR, 8'h03);
		reg_wr(`APP_OFF_CFG, 8'h01);
		reg_wr(`APP_OFF_DATA0, 8'h11);
		chk_read(1'b0, 3'b011, 24'h003c11, 1'b0);
		cmp("irq", 24'h1, 24'(irq));
		reg_wr(`APP_OFF_IRQ_CLR, 8'h01);
		reg_wr(`APP_OFF_ENABLE, 8'h00);
		reg_rd(`APP_OFF_ENABLE, 8'h00);
		cmp("hs_oe", 24'h0, 24'(hs_oe));
		chk_read(1'b0, 3'b000, 24'h0, 1'b0);
		reg_rd(`APP_OFF_IRQ_STAT, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
